/* File: logic/iole_exec.sv */
// Executes bump, bump-and-skip, OR-literal and load-literal instruction words.
// Assumes REG_RDATA holds the register named by INSTR in the same cycle.
module iole_exec (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic INSTR_VALID,
  input wire iole_pkg::iole_instr_t INSTR,
  input wire logic [iole_pkg::IOLE_DATA_W-1:0] REG_RDATA,
  output iole_pkg::iole_wr_t REG_WR,
  output logic [iole_pkg::IOLE_DATA_W-1:0] ACC,
  output logic NULL_FLAG,
  output logic FLUSH
);
  import iole_pkg::*;

  iole_state_t state;
  iole_state_t next_state;
  logic [IOLE_DATA_W-1:0] inc_sum;
  logic inc_zero;
  wire live = CE && INSTR_VALID && (state == IOLE_RUN);
  wire dropped = CE && INSTR_VALID && (state == IOLE_DISCARD);
  wire [IOLE_DATA_W-1:0] literal_value = {INSTR.target, INSTR.addr};
  wire is_bump = live && (INSTR.op == IOLE_OP_BUMP);
  wire is_skip = live && (INSTR.op == IOLE_OP_BUMP_SKIP);
  wire is_or = live && (INSTR.op == IOLE_OP_OR_IMM);
  wire is_load = live && (INSTR.op[IOLE_LOAD_TOP_MSB:IOLE_LOAD_TOP_LSB] == IOLE_OP_LOAD_IMM);
  wire any_bump = is_bump || is_skip;
  wire to_acc = (INSTR.target == IOLE_DEST_ACC);
  wire [IOLE_DATA_W-1:0] or_value = ACC | literal_value;
  wire acc_load = (any_bump && to_acc) || is_or || is_load;
  wire reg_load = any_bump && !to_acc;
  wire skip_taken = is_skip && inc_zero;

  iole_inc #(.W(IOLE_DATA_W)) u_inc (
    .value(REG_RDATA),
    .sum(inc_sum),
    .zero(inc_zero)
  );

  // Selects the accumulator value for bump, OR and load.
  logic [IOLE_DATA_W-1:0] next_acc;
  always_comb begin
    next_acc = ACC;
    if (any_bump && to_acc) begin
      next_acc = inc_sum;
    end else if (is_or) begin
      next_acc = or_value;
    end else if (is_load) begin
      next_acc = literal_value;
    end
  end

  // Plain bump and OR set the null flag; skip and load leave it alone.
  logic next_null;
  always_comb begin
    next_null = NULL_FLAG;
    if (is_bump) begin
      next_null = inc_zero;
    end else if (is_or) begin
      next_null = (or_value == '0);
    end
  end

  // A zero skip result turns the following instruction into a no-operation.
  always_comb begin
    next_state = state;
    case (state)
      IOLE_RUN: begin
        if (skip_taken) begin
          next_state = IOLE_DISCARD;
        end
      end
      IOLE_DISCARD: begin
        if (dropped) begin
          next_state = IOLE_RUN;
        end
      end
      default: next_state = IOLE_RUN;
    endcase
  end

  // Enabled cycles without a register write show an all-zero write bus; while CE is low the bus holds its last value.
  wire [IOLE_ADDR_W-1:0] wr_addr = reg_load ? INSTR.addr : '0;
  wire [IOLE_DATA_W-1:0] wr_data = reg_load ? inc_sum : '0;
  wire iole_wr_t next_wr = '{we: reg_load, addr: wr_addr, data: wr_data};

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= IOLE_RUN;
    end else if (CE) begin
      state <= next_state;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACC <= IOLE_ACC_RESET;
    end else if (CE) begin
      ACC <= next_acc;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      NULL_FLAG <= IOLE_NULL_RESET;
    end else if (CE) begin
      NULL_FLAG <= next_null;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_WR <= '0;
    end else if (CE) begin
      REG_WR <= next_wr;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FLUSH <= 1'b0;
    end else if (CE) begin
      FLUSH <= skip_taken;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  bump_to_acc_a: assert property (
    is_bump && to_acc |=> ACC == 8'($past(REG_RDATA) + 8'h01) && !REG_WR.we
      && NULL_FLAG == (8'($past(REG_RDATA) + 8'h01) == 8'h00))
    else $error("bump to accumulator gave wrong value or flag");
  bump_to_reg_a: assert property (
    is_bump && !to_acc |=> REG_WR.we && REG_WR.data == 8'($past(REG_RDATA) + 8'h01)
      && REG_WR.addr == $past(INSTR.addr) && $stable(ACC))
    else $error("bump to register gave wrong write");
  skip_keeps_null_a: assert property (
    is_skip |=> $stable(NULL_FLAG))
    else $error("bump and skip changed the null flag");

  sequence skip_zero_s;
    is_skip && REG_RDATA == 8'hff;
  endsequence
  sequence discard_s;
    FLUSH && state == IOLE_DISCARD;
  endsequence
  skip_flush_a: assert property (
    skip_zero_s |=> discard_s)
    else $error("zero skip result did not flush");
  skip_nop_a: assert property (
    dropped |=> $stable(ACC) && $stable(NULL_FLAG) && !REG_WR.we && state == IOLE_RUN)
    else $error("discarded instruction had an effect");
  skip_nonzero_a: assert property (
    is_skip && REG_RDATA != 8'hff |=> !FLUSH && state == IOLE_RUN)
    else $error("nonzero skip result flushed");
  or_acc_a: assert property (
    is_or |=> ACC == ($past(ACC) | $past(literal_value)) && NULL_FLAG == (ACC == 8'h00))
    else $error("OR literal gave wrong accumulator or flag");
  or_no_write_a: assert property (
    is_or |=> !REG_WR.we)
    else $error("OR literal wrote a data register");
  load_acc_a: assert property (
    is_load |=> ACC == $past(literal_value) && $stable(NULL_FLAG) && !REG_WR.we)
    else $error("load literal gave wrong accumulator or touched flags");

  // Nothing moves while the clock enable is low.
  freeze_all_a: assert property (
    !CE |=> $stable(ACC) && $stable(NULL_FLAG) && $stable(REG_WR) && $stable(FLUSH)
      && $stable(state))
    else $error("state moved while the clock enable was low");

  acc_hold_a: assert property (
    !acc_load |=> $stable(ACC))
    else $error("accumulator changed without an accumulator write");

  idle_bus_a: assert property (
    CE && !reg_load |=> REG_WR == '0)
    else $error("write bus not idle without a register write");

  bump_single_a: assert property (
    is_bump |=> !FLUSH && state == IOLE_RUN)
    else $error("plain bump started a discard");

  skip_to_acc_a: assert property (
    is_skip && to_acc |=> ACC == 8'($past(REG_RDATA) + 8'h01) && !REG_WR.we)
    else $error("bump and skip to accumulator gave wrong value");

  skip_to_reg_a: assert property (
    is_skip && !to_acc |=> REG_WR.we && REG_WR.data == 8'($past(REG_RDATA) + 8'h01)
      && REG_WR.addr == $past(INSTR.addr) && $stable(ACC))
    else $error("bump and skip to register gave wrong write");

  null_keep_a: assert property (
    !is_bump && !is_or |=> $stable(NULL_FLAG))
    else $error("null flag changed outside bump and OR");

  flush_state_a: assert property (
    FLUSH |-> state == IOLE_DISCARD)
    else $error("flush shown outside a discard");

  discard_wait_a: assert property (
    state == IOLE_DISCARD && !dropped |=> state == IOLE_DISCARD)
    else $error("discard ended without a dropped instruction");

  discard_no_flag_a: assert property (
    dropped |=> !FLUSH)
    else $error("dropped instruction raised a flush");

  sequence drop_next_s;
    dropped;
  endsequence
  skip_drop_a: assert property (
    discard_s ##0 drop_next_s |=> !FLUSH && state == IOLE_RUN)
    else $error("dropped instruction did not end the discard");

  or_single_a: assert property (
    is_or |=> !FLUSH && state == IOLE_RUN)
    else $error("OR literal started a discard");

  load_single_a: assert property (
    is_load |=> !FLUSH && state == IOLE_RUN)
    else $error("load literal started a discard");
endmodule

/* File: logic/iole_pkg.sv */
// Constants, opcode patterns and carrier types for the increment and literal executor.
// Assumes a core that presents one instruction word a cycle with its register operand.
// How it works
// - Bump register, route by select, update null.
// - Bump register, route by select, keep null.
// - Zero skip result discards next fetched instruction.
// - OR literal into accumulator, update null flag.
// - OR literal never writes a data register.
package iole_pkg;
  localparam int IOLE_DATA_W = 8;
  localparam int IOLE_ADDR_W = 7;
  localparam int IOLE_WORD_W = 14;
  localparam int IOLE_OP_W = 6;
  localparam logic [5:0] IOLE_OP_BUMP = 6'h0a;
  localparam logic [5:0] IOLE_OP_BUMP_SKIP = 6'h0f;
  localparam logic [5:0] IOLE_OP_OR_IMM = 6'h38;
  localparam logic [3:0] IOLE_OP_LOAD_IMM = 4'hc;
  localparam int IOLE_LOAD_TOP_MSB = 5;
  localparam int IOLE_LOAD_TOP_LSB = 2;
  localparam logic IOLE_DEST_ACC = 1'b0;
  localparam logic [7:0] IOLE_ACC_RESET = 8'h00;
  localparam logic IOLE_NULL_RESET = 1'b0;

  typedef struct packed {
    logic [5:0] op;
    logic target;
    logic [6:0] addr;
  } iole_instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } iole_wr_t;

  typedef enum logic {IOLE_RUN, IOLE_DISCARD} iole_state_t;
endpackage

/* File: logic/iole_inc.sv */
// Adds one to a data word and flags a zero result.
// Assumes a purely combinational use inside the executor.
module iole_inc #(
  parameter int W = 8
) (
  input wire logic [W-1:0] value,
  output logic [W-1:0] sum,
  output logic zero
);
  assign sum = value + W'(1);
  assign zero = (sum == '0);
endmodule

/* File: bench/increment_or_literal_exec_bench.sv */
// Bench for the increment and literal executor.
// Assumes results show one cycle after each instruction is taken.
module increment_or_literal_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iole_pkg::*;
  logic SYS_CLK = 0, RESETN = 0, CE = 1, INSTR_VALID = 0;
  iole_instr_t INSTR = '0;
  logic [7:0] REG_RDATA = 8'h00;
  iole_wr_t REG_WR;
  logic [7:0] ACC;
  logic NULL_FLAG, FLUSH;
  int compares = 0, miscompares = 0;
  iole_exec iole_exec_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CE(CE),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .REG_RDATA(REG_RDATA),
    .REG_WR(REG_WR), .ACC(ACC), .NULL_FLAG(NULL_FLAG), .FLUSH(FLUSH));
  initial begin
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Presents one word for one cycle; valid stays up for back-to-back use.
  task automatic run(input logic [5:0] op, input logic [7:0] k, input logic [7:0] rd);
    INSTR = {op, k};
    REG_RDATA = rd;
    INSTR_VALID = 1'b1;
    @(negedge SYS_CLK);
  endtask
  task automatic out(input logic [15:0] wr, input logic [7:0] acc, input logic [1:0] ff);
    chk("reg_wr", {1'b0, wr}, {1'b0, REG_WR});
    chk("acc", {9'h000, acc}, {9'h000, ACC});
    chk("null_flush", {15'h0000, ff}, {15'h0000, NULL_FLAG, FLUSH});
  endtask
  task automatic t_bump();
    run(6'h0a, 8'h12, 8'hff);
    out(16'h0000, 8'h00, 2'b10);
    run(6'h0a, 8'hff, 8'h41);
    out(16'hff42, 8'h00, 2'b00);
  endtask
  task automatic t_load();
    run(6'h0a, 8'h03, 8'hff);
    for (int i = 0; i < 4; i++) begin
      run(6'h30 + i[5:0], 8'h5a ^ i[7:0], 8'h00);
      out(16'h0000, 8'h5a ^ i[7:0], 2'b10);
    end
  endtask
  task automatic t_or();
    run(6'h31, 8'h9a, 8'h00);
    run(6'h38, 8'h35, 8'h77);
    out(16'h0000, 8'hbf, 2'b00);
    run(6'h30, 8'h00, 8'h00);
    run(6'h38, 8'h00, 8'h00);
    out(16'h0000, 8'h00, 2'b10);
  endtask
  task automatic t_skip();
    run(6'h33, 8'h66, 8'h00);
    run(6'h0f, 8'h85, 8'hff);
    out(16'h8500, 8'h66, 2'b11);
    INSTR_VALID = 1'b0;
    @(negedge SYS_CLK);
    run(6'h30, 8'h77, 8'h00);
    out(16'h0000, 8'h66, 2'b10);
    run(6'h30, 8'h22, 8'h00);
    run(6'h0f, 8'h01, 8'h10);
    out(16'h0000, 8'h11, 2'b10);
  endtask
  task automatic t_hold();
    CE = 1'b0;
    run(6'h30, 8'h3c, 8'h00);
    out(16'h0000, 8'h11, 2'b10);
    CE = 1'b1;
    run(6'h30, 8'h3c, 8'h00);
    out(16'h0000, 8'h3c, 2'b10);
  endtask
  task automatic t_reset();
    INSTR_VALID = 1'b0;
    RESETN = 1'b0;
    @(negedge SYS_CLK);
    out(16'h0000, 8'h00, 2'b00);
    RESETN = 1'b1;
    run(6'h0f, 8'h80, 8'hff);
    out(16'h8000, 8'h00, 2'b01);
    run(6'h30, 8'h44, 8'h00);
    out(16'h0000, 8'h00, 2'b00);
    INSTR_VALID = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #4000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge SYS_CLK);
    RESETN = 1'b1;
    out(16'h0000, 8'h00, 2'b00);
    t_bump();
    t_load();
    t_or();
    t_skip();
    t_hold();
    t_reset();
    @(negedge SYS_CLK);
    tally_and_finish();
  end
endmodule
